/* core/dmac_pkg.sv */
// Package of constants for the four-channel transfer controller.
// Assumes a single 25 MHz system clock; no imports anywhere, full scoping.
package dmac_pkg;
  localparam int NUM_CH = 4;
  localparam int CLK_PERIOD_NS = 40;
  // Least reset pulse, rounded up to whole cycles.
  localparam int RESET_MIN_NS = 300;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Cycles the host waits after reset before the first write.
  localparam int POST_RESET_CYC = 2;
  // Register select codes on the low address lines.
  localparam logic [3:0] REG_ADDR_LO = 4'h0;
  localparam logic [3:0] REG_ADDR_HI = 4'h1;
  localparam logic [3:0] REG_COUNT_LO = 4'h2;
  localparam logic [3:0] REG_COUNT_HI = 4'h3;
  localparam logic [3:0] REG_CHAN_SEL = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_COMMAND = 4'h9;
  localparam logic [3:0] REG_SW_REQ = 4'ha;
  localparam logic [3:0] REG_MASK_ONE = 4'hb;
  localparam logic [3:0] REG_MODE = 4'hc;
  localparam logic [3:0] REG_MASK_ALL = 4'hf;
  // Command register fields.
  localparam int CMD_DISABLE_BIT = 2;
  localparam int CMD_REQ_LOW_BIT = 6;
  localparam int CMD_GNT_HIGH_BIT = 7;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [3:0] MASK_RESET = 4'hf;
  // Mode register fields: bit 2 set means write to memory.
  localparam int MODE_TO_MEM_BIT = 2;
  localparam int MODE_DEC_BIT = 5;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [5:0] {
    DMAC_IDLE = 6'b000001,
    DMAC_HOLD = 6'b000010,
    DMAC_ADDR = 6'b000100,
    DMAC_STRB = 6'b001000,
    DMAC_WAIT = 6'b010000,
    DMAC_DONE = 6'b100000
  } dmac_state_t;
endpackage

/* core/dmac_sync.sv */
// Three-stage synchroniser for pins from outside the clock domain.
// Assumes pin inputs may change at any time relative to sys_clk.
`timescale 1ns/10ps
module dmac_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_out <= INIT;
    end else if (clk_en) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A bit changes only once two later stages agree.
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

/* core/dmac_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; depth must be a power of two.
`timescale 1ns/10ps
module dmac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("dmac_fifo: depth must be a power of two of 2 or more");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (clk_en) begin
      if (flush) begin
        wr_q <= '0;
        rd_q <= '0;
      end else begin
        if (push) begin
          wr_q <= wr_q + 1'b1;
        end
        if (pop) begin
          rd_q <= rd_q + 1'b1;
        end
      end
    end
  end
endmodule

/* core/dmac_core.sv */
// Four-channel transfer controller: host handshake, register port,
// address generation with external high-byte latch, strobes and EOP.
// Assumes one 25 MHz clock; all pins other than the clock arrive async.
`timescale 1ns/10ps
module dmac_core #(
  parameter int NUM_CH = dmac_pkg::NUM_CH,
  parameter int FIFO_DEPTH = dmac_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic device_select_n,
  input wire logic ready,
  input wire logic bus_hold_grant,
  input wire logic [NUM_CH-1:0] dma_request_inputs,
  output logic bus_hold_request,
  output logic [NUM_CH-1:0] dma_grant_outputs,
  input wire logic [3:0] register_select_lines_in,
  output logic [3:0] register_select_lines_out,
  output logic register_select_lines_oe,
  output logic [3:0] middle_address_lines,
  output logic middle_address_oe,
  input wire logic [7:0] shared_data_bus_in,
  output logic [7:0] shared_data_bus_out,
  output logic shared_data_bus_oe,
  output logic high_address_strobe,
  output logic high_address_output_enable,
  input wire logic io_read_strobe_n_in,
  output logic io_read_strobe_n_out,
  input wire logic io_write_strobe_n_in,
  output logic io_write_strobe_n_out,
  output logic io_strobe_oe,
  output logic memory_read_strobe_n,
  output logic memory_write_strobe_n,
  output logic mem_strobe_oe,
  input wire logic end_of_process_signal_n_in,
  output logic end_of_process_signal_n_out,
  output logic end_of_process_signal_oe,
  output logic [7:0] status_q
);
  initial begin
    if (NUM_CH != 4) begin
      $error("dmac_core: the register map serves exactly four channels");
    end
  end

  // Internal reset is active low so leaves share one convention.
  logic reset_n;
  assign reset_n = !reset;

  // Pins from the host bus and peripherals are synchronised.
  logic [NUM_CH-1:0] req_raw;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic eop_in_n;
  logic hold_gnt;
  logic rdy;
  logic [3:0] a_in;
  logic [7:0] d_in;
  dmac_sync #(.WIDTH(NUM_CH + 5), .INIT({{NUM_CH{1'b0}}, 5'h1f})) u_sync_ctl (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_in({dma_request_inputs, device_select_n, io_read_strobe_n_in,
             io_write_strobe_n_in, end_of_process_signal_n_in, ready}),
    .level_out({req_raw, cs_n, rd_n, wr_n, eop_in_n, rdy})
  );
  dmac_sync #(.WIDTH(13), .INIT(13'h0)) u_sync_bus (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_in({bus_hold_grant, register_select_lines_in, shared_data_bus_in}),
    .level_out({hold_gnt, a_in, d_in})
  );

  // Control registers.
  logic [7:0] cmd_q;
  logic [3:0] mask_q;
  logic [3:0] sw_req_q;
  logic [1:0] sel_ch_q;
  logic [7:0] mode_q [NUM_CH];
  logic [15:0] addr_q [NUM_CH];
  logic [15:0] count_q [NUM_CH];
  logic byte_ptr_q;
  logic wr_d1_q;
  logic rd_d1_q;
  dmac_pkg::dmac_state_t state_q;
  logic [1:0] act_ch_q;
  logic [7:0] last_hi_q;
  logic hi_valid_q;

  // Request polarity follows the command register; reset gives active high.
  logic [NUM_CH-1:0] req_act;
  assign req_act = (cmd_q[dmac_pkg::CMD_REQ_LOW_BIT] ? ~req_raw : req_raw)
                   | sw_req_q;
  logic [NUM_CH-1:0] pending;
  assign pending = cmd_q[dmac_pkg::CMD_DISABLE_BIT] ? '0
                   : (req_act & ~mask_q);

  logic busy;
  assign busy = state_q != dmac_pkg::DMAC_IDLE;
  // Select counts only while idle and the host still owns the bus.
  logic host_acc;
  assign host_acc = !cs_n && !hold_gnt && !busy;
  logic wr_edge;
  logic rd_edge;
  assign wr_edge = host_acc && !wr_n && wr_d1_q;
  assign rd_edge = host_acc && !rd_n && rd_d1_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_d1_q <= 1'b1;
      rd_d1_q <= 1'b1;
    end else if (clk_en) begin
      wr_d1_q <= wr_n;
      rd_d1_q <= rd_n;
    end
  end

  // Register writes; reset clears all but the mask, which disables all.
  logic tc_hit;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q <= dmac_pkg::CMD_RESET;
      mask_q <= dmac_pkg::MASK_RESET;
      sw_req_q <= 4'h0;
      sel_ch_q <= 2'h0;
      byte_ptr_q <= 1'b0;
    end else if (clk_en) begin
      if (tc_hit) begin
        sw_req_q[act_ch_q] <= 1'b0;
      end
      // A finished or cut channel masks itself, so a request still held
      // high cannot restart it while the stale grant drains away.
      if (state_q == dmac_pkg::DMAC_DONE) begin
        mask_q[act_ch_q] <= 1'b1;
      end
      if (wr_edge) begin
        case (a_in)
          dmac_pkg::REG_ADDR_LO, dmac_pkg::REG_ADDR_HI,
          dmac_pkg::REG_COUNT_LO, dmac_pkg::REG_COUNT_HI: begin
            byte_ptr_q <= !byte_ptr_q;
          end
          dmac_pkg::REG_CHAN_SEL: sel_ch_q <= d_in[1:0];
          dmac_pkg::REG_COMMAND: cmd_q <= d_in;
          dmac_pkg::REG_SW_REQ: sw_req_q[d_in[1:0]] <= d_in[2];
          dmac_pkg::REG_MASK_ONE: mask_q[d_in[1:0]] <= d_in[2];
          dmac_pkg::REG_MASK_ALL: mask_q <= d_in[3:0];
          default: ;
        endcase
      end
    end
  end

  // Per-channel address and count, loaded a byte at a time.
  logic [15:0] step_addr;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mode_q[i] <= dmac_pkg::MODE_RESET;
        addr_q[i] <= 16'h0000;
        count_q[i] <= 16'h0000;
      end
    end else if (clk_en) begin
      if (wr_edge) begin
        case (a_in)
          dmac_pkg::REG_ADDR_LO, dmac_pkg::REG_ADDR_HI: begin
            if (byte_ptr_q) addr_q[sel_ch_q][15:8] <= d_in;
            else addr_q[sel_ch_q][7:0] <= d_in;
          end
          dmac_pkg::REG_COUNT_LO, dmac_pkg::REG_COUNT_HI: begin
            if (byte_ptr_q) count_q[sel_ch_q][15:8] <= d_in;
            else count_q[sel_ch_q][7:0] <= d_in;
          end
          dmac_pkg::REG_MODE: mode_q[sel_ch_q] <= d_in;
          default: ;
        endcase
      end
      if (state_q == dmac_pkg::DMAC_STRB && rdy) begin
        addr_q[act_ch_q] <= step_addr;
        count_q[act_ch_q] <= count_q[act_ch_q] - 16'h0001;
      end
    end
  end
  assign step_addr = mode_q[act_ch_q][dmac_pkg::MODE_DEC_BIT]
                     ? addr_q[act_ch_q] - 16'h0001
                     : addr_q[act_ch_q] + 16'h0001;

  // Fixed priority: channel 0 highest.
  logic [1:0] win_ch;
  always_comb begin
    win_ch = 2'd0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pending[i]) win_ch = 2'(i);
    end
  end

  // Register read data passes through the FIFO so reads queue in order.
  logic [7:0] rd_data;
  always_comb begin
    case (a_in)
      dmac_pkg::REG_STATUS: rd_data = status_q;
      dmac_pkg::REG_COMMAND: rd_data = cmd_q;
      dmac_pkg::REG_ADDR_LO, dmac_pkg::REG_ADDR_HI:
        rd_data = byte_ptr_q ? addr_q[sel_ch_q][15:8]
                             : addr_q[sel_ch_q][7:0];
      dmac_pkg::REG_COUNT_LO, dmac_pkg::REG_COUNT_HI:
        rd_data = byte_ptr_q ? count_q[sel_ch_q][15:8]
                             : count_q[sel_ch_q][7:0];
      default: rd_data = {4'h0, mask_q};
    endcase
  end
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic drive_rd_q;
  dmac_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .flush(busy),
    .in_valid(rd_edge),
    .in_ready(fifo_in_ready),
    .in_data(rd_data),
    .out_valid(fifo_out_valid),
    .out_ready(!drive_rd_q),
    .out_data(fifo_out_data)
  );

  // Transfer sequencer.
  logic eop_ext;
  assign eop_ext = !eop_in_n && !end_of_process_signal_oe;
  assign tc_hit = state_q == dmac_pkg::DMAC_STRB && rdy
                  && count_q[act_ch_q] == 16'h0000;
  logic to_mem;
  assign to_mem = mode_q[act_ch_q][dmac_pkg::MODE_TO_MEM_BIT];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= dmac_pkg::DMAC_IDLE;
      act_ch_q <= 2'd0;
      hi_valid_q <= 1'b0;
      last_hi_q <= 8'h00;
    end else if (clk_en) begin
      case (state_q)
        dmac_pkg::DMAC_IDLE: begin
          if (pending != '0) state_q <= dmac_pkg::DMAC_HOLD;
        end
        dmac_pkg::DMAC_HOLD: begin
          // The host grants only once it has let go of the buses.
          if (hold_gnt && pending != '0) begin
            act_ch_q <= win_ch;
            hi_valid_q <= 1'b0;
            state_q <= dmac_pkg::DMAC_ADDR;
          end else if (pending == '0) begin
            state_q <= dmac_pkg::DMAC_IDLE;
          end
        end
        dmac_pkg::DMAC_ADDR: begin
          last_hi_q <= addr_q[act_ch_q][15:8];
          hi_valid_q <= 1'b1;
          state_q <= dmac_pkg::DMAC_STRB;
        end
        dmac_pkg::DMAC_STRB: begin
          if (eop_ext || tc_hit) begin
            state_q <= dmac_pkg::DMAC_DONE;
          end else if (!rdy) begin
            state_q <= dmac_pkg::DMAC_WAIT;
          end else if (step_addr[15:8] != last_hi_q) begin
            // The high byte is re-strobed only on a carry or borrow.
            state_q <= dmac_pkg::DMAC_ADDR;
          end
        end
        dmac_pkg::DMAC_WAIT: begin
          if (eop_ext) state_q <= dmac_pkg::DMAC_DONE;
          else if (rdy) state_q <= dmac_pkg::DMAC_STRB;
        end
        dmac_pkg::DMAC_DONE: state_q <= dmac_pkg::DMAC_IDLE;
        default: state_q <= dmac_pkg::DMAC_IDLE;
      endcase
    end
  end

  // Registered pin drive; every output comes straight from a flip-flop.
  logic on_bus;
  assign on_bus = state_q == dmac_pkg::DMAC_ADDR
                  || state_q == dmac_pkg::DMAC_STRB
                  || state_q == dmac_pkg::DMAC_WAIT;
  logic strobe_on;
  assign strobe_on = state_q == dmac_pkg::DMAC_STRB
                     || state_q == dmac_pkg::DMAC_WAIT;
  logic gnt_pol;
  assign gnt_pol = cmd_q[dmac_pkg::CMD_GNT_HIGH_BIT];

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_hold_request <= 1'b0;
      dma_grant_outputs <= '1;
      high_address_output_enable <= 1'b0;
      high_address_strobe <= 1'b0;
      register_select_lines_out <= 4'h0;
      register_select_lines_oe <= 1'b0;
      middle_address_lines <= 4'h0;
      middle_address_oe <= 1'b0;
      shared_data_bus_out <= 8'h00;
      shared_data_bus_oe <= 1'b0;
      drive_rd_q <= 1'b0;
      io_read_strobe_n_out <= 1'b1;
      io_write_strobe_n_out <= 1'b1;
      io_strobe_oe <= 1'b0;
      memory_read_strobe_n <= 1'b1;
      memory_write_strobe_n <= 1'b1;
      mem_strobe_oe <= 1'b0;
      end_of_process_signal_n_out <= 1'b1;
      end_of_process_signal_oe <= 1'b0;
      status_q <= 8'h00;
    end else if (clk_en) begin
      bus_hold_request <= (state_q == dmac_pkg::DMAC_HOLD)
                          || on_bus;
      // One-hot grant so no two channels are ever acknowledged together.
      for (int i = 0; i < NUM_CH; i++) begin
        dma_grant_outputs[i] <= (on_bus && act_ch_q == 2'(i))
                                ? gnt_pol : !gnt_pol;
      end
      high_address_output_enable <= on_bus;
      high_address_strobe <= state_q == dmac_pkg::DMAC_ADDR;
      register_select_lines_out <= addr_q[act_ch_q][3:0];
      register_select_lines_oe <= on_bus;
      middle_address_lines <= addr_q[act_ch_q][7:4];
      middle_address_oe <= on_bus;
      // Read data is held until the host strobe rises again.
      drive_rd_q <= drive_rd_q ? !rd_n : fifo_out_valid && !rd_n;
      if (state_q == dmac_pkg::DMAC_ADDR) begin
        shared_data_bus_out <= addr_q[act_ch_q][15:8];
      end else if (!drive_rd_q && fifo_out_valid) begin
        shared_data_bus_out <= fifo_out_data;
      end
      shared_data_bus_oe <= (state_q == dmac_pkg::DMAC_ADDR)
                            || (drive_rd_q && !rd_n && !cs_n);
      // Strobes stay low through wait states while Ready is low.
      io_read_strobe_n_out <= !(strobe_on && to_mem);
      memory_write_strobe_n <= !(strobe_on && to_mem);
      memory_read_strobe_n <= !(strobe_on && !to_mem);
      io_write_strobe_n_out <= !(strobe_on && !to_mem);
      io_strobe_oe <= on_bus;
      mem_strobe_oe <= on_bus;
      end_of_process_signal_n_out <= !tc_hit;
      end_of_process_signal_oe <= tc_hit;
      // Terminal-count flags set on completion and clear on status read.
      for (int i = 0; i < NUM_CH; i++) begin
        if (tc_hit && act_ch_q == 2'(i)) status_q[i] <= 1'b1;
        else if (rd_edge && a_in == dmac_pkg::REG_STATUS) status_q[i] <= 1'b0;
        status_q[4 + i] <= req_act[i];
      end
    end
  end
endmodule

/* sim/dmac_core_asserts.sv */
// Concurrent checks on the ports of the transfer controller.
// Assumes one clock and the active-high asynchronous reset of the core.
`timescale 1ns/10ps
module dmac_core_chk #(
  parameter int NUM_CH = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic bus_hold_request,
  input wire logic bus_hold_grant,
  input wire logic [NUM_CH-1:0] dma_grant_outputs,
  input wire logic register_select_lines_oe,
  input wire logic middle_address_oe,
  input wire logic shared_data_bus_oe,
  input wire logic high_address_strobe,
  input wire logic high_address_output_enable,
  input wire logic io_write_strobe_n_out,
  input wire logic io_strobe_oe,
  input wire logic memory_read_strobe_n,
  input wire logic memory_write_strobe_n,
  input wire logic mem_strobe_oe,
  input wire logic end_of_process_signal_n_out,
  input wire logic end_of_process_signal_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence eop_out_s;
    end_of_process_signal_oe && !end_of_process_signal_n_out;
  endsequence
  sequence hold_gone_s;
    ##[1:8] !bus_hold_request;
  endsequence
  // The reset check must stay live while reset is high.
  reset_idle_a: assert property (disable iff (1'b0) reset |->
    !bus_hold_request && !io_strobe_oe && !mem_strobe_oe &&
    !high_address_output_enable && !middle_address_oe)
    else $error("outputs not idle in reset");
  one_grant_a: assert property ($onehot0(dma_grant_outputs) ||
    $onehot0(~dma_grant_outputs)) else $error("two grants active");
  enable_hold_a: assert property ($rose(high_address_output_enable)
    |-> bus_hold_request && bus_hold_grant)
    else $error("address enable without granted hold");
  strobe_pulse_a: assert property (high_address_strobe |=>
    !high_address_strobe) else $error("address strobe too long");
  strobe_bus_a: assert property (high_address_strobe |->
    shared_data_bus_oe && high_address_output_enable)
    else $error("high byte strobed off the bus");
  addr_drive_a: assert property ((middle_address_oe ||
    register_select_lines_oe) |-> high_address_output_enable)
    else $error("address lines driven outside transfer");
  mem_pair_a: assert property (!memory_write_strobe_n |->
    memory_read_strobe_n && io_write_strobe_n_out && mem_strobe_oe)
    else $error("bad strobe combination");
  eop_pulse_a: assert property (eop_out_s |=>
    end_of_process_signal_n_out) else $error("end pulse too long");
  eop_release_a: assert property (eop_out_s |-> hold_gone_s)
    else $error("hold kept after end of process");
endmodule

bind dmac_core dmac_core_chk #(.NUM_CH(NUM_CH)) chk_i (
  .sys_clk(sys_clk),
  .reset(reset),
  .bus_hold_request(bus_hold_request),
  .bus_hold_grant(bus_hold_grant),
  .dma_grant_outputs(dma_grant_outputs),
  .register_select_lines_oe(register_select_lines_oe),
  .middle_address_oe(middle_address_oe),
  .shared_data_bus_oe(shared_data_bus_oe),
  .high_address_strobe(high_address_strobe),
  .high_address_output_enable(high_address_output_enable),
  .io_write_strobe_n_out(io_write_strobe_n_out),
  .io_strobe_oe(io_strobe_oe),
  .memory_read_strobe_n(memory_read_strobe_n),
  .memory_write_strobe_n(memory_write_strobe_n),
  .mem_strobe_oe(mem_strobe_oe),
  .end_of_process_signal_n_out(end_of_process_signal_n_out),
  .end_of_process_signal_oe(end_of_process_signal_oe)
);

/* sim/dmac_host_model.sv */
// Host side model: hold grant handshake and external high-byte latch.
// Assumes the bench resolves the shared data bus wire.
`timescale 1ns/10ps
module dmac_host_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic bus_hold_request,
  input wire logic high_address_strobe,
  input wire logic high_address_output_enable,
  input wire logic [7:0] data_bus,
  output logic bus_hold_grant,
  output logic [7:0] high_addr
);
  logic req_seen_q;
  logic [7:0] latch_q;
  // Grant rises two cycles after request and falls one cycle after request drops.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      req_seen_q <= 1'b0;
      bus_hold_grant <= 1'b0;
    end else begin
      req_seen_q <= bus_hold_request;
      bus_hold_grant <= bus_hold_request & req_seen_q;
    end
  end
  // Taking the byte while the strobe is high equals its falling edge,
  // without racing the bus change made on that same edge.
  always_ff @(posedge sys_clk) begin
    if (high_address_strobe) begin
      latch_q <= data_bus;
    end
  end
  // A released address bus shows the inverse, never a stale byte.
  assign high_addr = high_address_output_enable ? latch_q : ~latch_q;
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the transfer controller with a host model.
// Assumes the core, its package and the checker are compiled first.
`timescale 1ns/10ps
module tb_top;
  logic sys_clk, reset, ready, tb_sel_n, tb_ior_n, tb_iow_n, tb_eop_n;
  logic [3:0] tb_a, req, dma_grant_outputs, register_select_lines_out;
  logic [3:0] middle_address_lines;
  logic [7:0] tb_db, shared_data_bus_out, status_q, hi_addr, rd_q;
  logic bus_hold_request, bus_hold_grant, register_select_lines_oe;
  logic middle_address_oe, shared_data_bus_oe, high_address_strobe;
  logic high_address_output_enable, io_read_strobe_n_out, io_strobe_oe;
  logic io_write_strobe_n_out, memory_read_strobe_n, memory_write_strobe_n;
  logic mem_strobe_oe, end_of_process_signal_n_out, end_of_process_signal_oe;
  logic [15:0] last_addr;
  wire logic [15:0] cur_addr = {hi_addr, middle_address_lines,
    register_select_lines_out};
  int n_mismatch = 0, num_checks = 0, n_wr = 0, base, i;
  wire logic [7:0] db = shared_data_bus_oe ? shared_data_bus_out : tb_db;
  wire logic [3:0] a_lo = register_select_lines_oe ?
    register_select_lines_out : tb_a;
  wire logic io_read_strobe = io_strobe_oe ? io_read_strobe_n_out : tb_ior_n;
  wire logic io_write_strobe = io_strobe_oe ? io_write_strobe_n_out : tb_iow_n;
  // The end-of-process wire falls back to tb_eop_n, driven high, so idle reads high.
  wire logic eop = end_of_process_signal_oe ?
    end_of_process_signal_n_out : tb_eop_n;
  dmac_core dut (.sys_clk, .reset, .clk_en(1'b1), .device_select_n(tb_sel_n),
    .ready, .bus_hold_grant, .dma_request_inputs(req), .bus_hold_request,
    .dma_grant_outputs, .register_select_lines_in(a_lo),
    .register_select_lines_out, .register_select_lines_oe,
    .middle_address_lines, .middle_address_oe, .shared_data_bus_in(db),
    .shared_data_bus_out, .shared_data_bus_oe, .high_address_strobe,
    .high_address_output_enable, .io_read_strobe_n_in(io_read_strobe),
    .io_read_strobe_n_out, .io_write_strobe_n_in(io_write_strobe), .io_write_strobe_n_out,
    .io_strobe_oe, .memory_read_strobe_n, .memory_write_strobe_n,
    .mem_strobe_oe, .end_of_process_signal_n_in(eop),
    .end_of_process_signal_n_out, .end_of_process_signal_oe, .status_q);
  dmac_host_model host (.sys_clk, .reset, .bus_hold_request,
    .high_address_strobe, .high_address_output_enable, .data_bus(db),
    .bus_hold_grant, .high_addr(hi_addr));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    // Back-to-back transfers keep the strobe low, so count new addresses.
    if (memory_write_strobe_n === 1'b0 && cur_addr !== last_addr) begin
      n_wr <= n_wr + 1;
      last_addr <= cur_addr;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Strobes are held well past the three-flop input synchroniser.
  task automatic host_io(input logic [3:0] a, input logic [7:0] d,
    input logic rd);
    @(posedge sys_clk);
    tb_sel_n <= 1'b0;
    tb_a <= a;
    tb_db <= rd ? 8'hff : d;
    tb_iow_n <= rd;
    tb_ior_n <= ~rd;
    tick(8);
    rd_q = shared_data_bus_out;
    tb_iow_n <= 1'b1;
    tb_ior_n <= 1'b1;
    tb_sel_n <= 1'b1;
    tb_db <= ~d;
    tick(3);
  endtask
  task automatic program_ch0(input logic [7:0] alo, input logic [7:0] cnt);
    host_io(dmac_pkg::REG_CHAN_SEL, 8'h00, 1'b0);
    host_io(dmac_pkg::REG_ADDR_LO, alo, 1'b0);
    host_io(dmac_pkg::REG_ADDR_HI, 8'h12, 1'b0);
    host_io(dmac_pkg::REG_COUNT_LO, cnt, 1'b0);
    host_io(dmac_pkg::REG_COUNT_HI, 8'h00, 1'b0);
    host_io(dmac_pkg::REG_MODE, 8'h04, 1'b0);
    host_io(dmac_pkg::REG_MASK_ALL, 8'h0e, 1'b0);
    base = n_wr;
    req <= 4'h1;
  endtask
  task automatic t_reset_idle;
    chk("grants", 16'hf, dma_grant_outputs);
    chk("mem oe", 16'h0, mem_strobe_oe);
    req <= 4'h1;
    tick(20);
    chk("masked hold", 16'h0, bus_hold_request);
    req <= 4'h0;
  endtask
  task automatic t_xfer;
    program_ch0(8'hfe, 8'h02);
    ready <= 1'b0;
    for (i = 0; i < 40 && bus_hold_request !== 1'b1; i++) tick(1);
    chk("hold", 16'h1, bus_hold_request);
    for (i = 0; i < 40 && dma_grant_outputs !== 4'he; i++) tick(1);
    chk("grant", 16'he, dma_grant_outputs);
    for (i = 0; i < 40 && memory_write_strobe_n !== 1'b0; i++) tick(1);
    chk("first addr", 16'h12fe, {hi_addr, middle_address_lines,
      register_select_lines_out});
    chk("io read", 16'h0, io_read_strobe_n_out);
    tick(8);
    chk("stretched", 16'h0, memory_write_strobe_n);
    ready <= 1'b1;
    for (i = 0; i < 200 && bus_hold_request !== 1'b0; i++) tick(1);
    tick(4);
    chk("released", 16'hf, dma_grant_outputs);
    chk("writes", 16'h3, n_wr - base);
    chk("last addr", 16'h1300, last_addr);
    req <= 4'h0;
    host_io(dmac_pkg::REG_STATUS, 8'h00, 1'b1);
    chk("tc flag", 16'h1, rd_q[3:0]);
  endtask
  task automatic t_eop;
    program_ch0(8'h00, 8'h40);
    for (i = 0; i < 80 && memory_write_strobe_n !== 1'b0; i++) tick(1);
    tb_eop_n <= 1'b0;
    tick(4);
    tb_eop_n <= 1'b1;
    for (i = 0; i < 40 && bus_hold_request !== 1'b0; i++) tick(1);
    chk("stopped", 16'h0, bus_hold_request);
    chk("cut short", 16'h1, (n_wr - base) < 20);
    req <= 4'h0;
    tick(4);
  endtask
  task automatic t_polarity;
    host_io(dmac_pkg::REG_COMMAND, 8'h80, 1'b0);
    chk("high grants", 16'h0, dma_grant_outputs);
    reset <= 1'b1;
    tick(8);
    reset <= 1'b0;
    tick(8);
    chk("reset grants", 16'hf, dma_grant_outputs);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #800000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {reset, ready, tb_sel_n, tb_ior_n, tb_iow_n, tb_eop_n} = 6'h3f;
    {tb_a, req, tb_db} = 16'h0000;
    // Held for the 300 ns minimum, then past the input synchroniser.
    tick(8);
    reset <= 1'b0;
    tick(6);
    t_reset_idle();
    t_xfer();
    t_eop();
    t_polarity();
    print_verdict();
  end
endmodule
